// file: cssc_pkg.sv
package cssc_pkg;

  // ==========================================================
  // timing
  localparam int CLK_HZ = 125_000_000;
  localparam int CT_SELF_HZ = 500_000;
  localparam int CT_MUT_HZ = 1_000_000;
  localparam int CT_SELF_CYC = CLK_HZ / CT_SELF_HZ;
  localparam int CT_MUT_CYC = CLK_HZ / CT_MUT_HZ;
  localparam int CT_SELF2_CYC = CLK_HZ / (2 * CT_SELF_HZ);
  localparam int CT_MUT2_CYC = CLK_HZ / (2 * CT_MUT_HZ);
  localparam real T_SAMPLE_MS = 2.6;
  localparam int SAMPLE_CYC = int'(T_SAMPLE_MS * 1.0e-3 * CLK_HZ);
  localparam real T_LP_UNIT_MS = 16.0;
  localparam int LP_UNIT_CYC = int'(T_LP_UNIT_MS * 1.0e-3 * CLK_HZ);
  localparam int LP_ONE_CYC = 1_000_000;
  localparam int LP_TWO_CYC = 3_000_000;

  // ==========================================================
  // geometry
  localparam int NCH = 4;
  localparam int CW = 12;
  localparam logic [11:0] CNT_MAX = 12'hfff;
  localparam int TGT_SCALE_SH = 3;
  localparam int BAND_SH = 3;
  localparam int AVG_SH = 4;

  // ==========================================================
  // register offsets
  localparam logic [7:0] A_SYSFLAG = 8'h10;
  localparam logic [7:0] A_EVENT = 8'h11;
  localparam logic [7:0] A_CHSEL = 8'h20;
  localparam logic [7:0] A_CNT_H = 8'h21;
  localparam logic [7:0] A_CNT_L = 8'h22;
  localparam logic [7:0] A_BASE_H = 8'h23;
  localparam logic [7:0] A_BASE_L = 8'h24;
  localparam logic [7:0] A_COMP = 8'h25;
  localparam logic [7:0] A_OPTION_BANK_ZERO = 8'h30;
  localparam logic [7:0] A_OPTION_BANK_TWO = 8'h31;
  localparam logic [7:0] A_GEST = 8'h32;
  localparam logic [7:0] A_PROXSET = 8'h33;
  localparam logic [7:0] A_LPINT = 8'h34;
  localparam logic [7:0] A_TGT_PROX = 8'h35;
  localparam logic [7:0] A_TGT_TOUCH = 8'h36;
  localparam logic [7:0] A_THR_PROX = 8'h37;
  localparam logic [7:0] A_THR_TOUCH = 8'h38;

  // ==========================================================
  // field positions and reset values
  localparam int B0_MUTUAL = 3;
  localparam int B0_FLOAT = 0;
  localparam int B2_DOUBLE = 0;
  localparam int G_THIRD_EN = 0;
  localparam int P_AT_OFF = 0;
  localparam int P_AT_PART = 1;
  localparam int P_RETUNE = 2;
  localparam int F_MUTUAL = 0;
  localparam int F_LP_ACT = 1;
  localparam int F_AT_RUN = 2;
  localparam logic [7:0] RST_TGT_PROX = 8'h28;
  localparam logic [7:0] RST_TGT_TOUCH = 8'h14;
  localparam logic [7:0] RST_THR_PROX = 8'h04;
  localparam logic [7:0] RST_THR_TOUCH = 8'h10;
  localparam logic [7:0] RST_COMP = 8'h80;
  localparam logic [3:0] MASK_NP = 4'h7;
  localparam logic [3:0] MASK_LP = 4'h1;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    ST_MEAS = 2'b00,
    ST_CALC = 2'b01,
    ST_WAIT = 2'b11,
    ST_SLEEP = 2'b10
  } cssc_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cssc_bus_t;

  typedef struct packed {
    logic [3:0] sel;
    logic [3:0] ground;
    logic xfer;
    logic [7:0] comp;
  } cssc_drive_t;

endpackage

// file: cssc_scan.sv
// Function
// - four slots, one shared sampling capacitor
// - idle channels grounded or floating, configurable
// - count transfers until trip voltage
// - count and baseline kept as 12 bits
// - self after reset, bank bit3 mutual, reported
// - default transfer rate 1MHz mutual, 500kHz self
// - rate double bit doubles transfer rate
// - normal power sample 2.6ms, fixed rate
// - disabled channel drops its slot
// - low power interval value times 16ms, except 1 and 2, which give 8ms and 24ms
// - low power charges channel zero once each interval
// - proximity event in low power zooms
// - low power flag when rate set, not zoomed
// - channels zero to two on; three by bit
// - low power measures proximity channel only
// - per-channel slow baseline, high and low bytes
// - self event: count below baseline minus threshold
// - mutual event: count above baseline plus threshold
// - proximity threshold ch0, touch threshold others
// - tuning on; off when disable and partial
// - tuning running flag while tuning
// - compensation toward target times eight
// - retune when count leaves target band
// - retune request cleared once tuning starts
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ps

module cssc_scan #(
  parameter int SAMPLE_CYC = cssc_pkg::SAMPLE_CYC,
  parameter int LP_UNIT_CYC = cssc_pkg::LP_UNIT_CYC,
  parameter int LP_ONE_CYC = cssc_pkg::LP_ONE_CYC,
  parameter int LP_TWO_CYC = cssc_pkg::LP_TWO_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // register port
  input wire cssc_pkg::cssc_bus_t busReq,
  output logic [7:0] regRdata,
  // analogue front end
  input wire logic tripIn,
  output cssc_pkg::cssc_drive_t drive,
  output logic [3:0] eventOut
);

  // ==========================================================
  // state
  typedef struct packed {
    cssc_pkg::cssc_state_t st;
    logic [1:0] ch;
    logic [7:0] div;
    logic [11:0] xcnt;
    logic [19:0] slotTmr;
    logic [31:0] lpTmr;
    logic [3:0][11:0] cnt;
    logic [3:0][11:0] base;
    logic [3:0][7:0] comp;
    logic [3:0] evt;
    logic [3:0] baseOk;
    logic [3:0] tuneOk;
    logic tuning;
    logic zoom;
    logic [7:0] option_bank_zero;
    logic [7:0] option_bank_two;
    logic [7:0] gest;
    logic [7:0] proxSet;
    logic [7:0] lpInt;
    logic [7:0] tgtProx;
    logic [7:0] tgtTouch;
    logic [7:0] thrProx;
    logic [7:0] thrTouch;
    logic [1:0] rdCh;
    logic [7:0] rdata;
    cssc_pkg::cssc_drive_t drv;
  } cssc_regs_t;

  cssc_regs_t q;
  cssc_regs_t n;

  assign regRdata = q.rdata;
  assign drive = q.drv;
  assign eventOut = q.evt;

  // ==========================================================
  // helpers
  function automatic logic [1:0] cssc_next(
    input logic [1:0] cur,
    input logic [3:0] en
  );
    logic [1:0] r;
    logic [1:0] c;
    r = cur;
    c = cur;
    for (int i = 0; i < 4; i++) begin
      c = c + 2'd1;
      if (en[c] && r == cur) begin
        r = c;
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] cssc_cyc(input int v);
    return v[7:0];
  endfunction

  function automatic logic [31:0] cssc_lp(input logic [7:0] v);
    logic [31:0] r;
    case (v)
      8'h01: r = LP_ONE_CYC[31:0];
      8'h02: r = LP_TWO_CYC[31:0];
      default: r = 32'(v) * LP_UNIT_CYC[31:0];
    endcase
    return r;
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    logic mutual;
    logic lpAct;
    logic atOn;
    logic [3:0] enMask;
    logic [7:0] perCyc;
    logic [11:0] c;
    logic [11:0] b;
    logic [12:0] thr;
    logic [12:0] tgt;
    logic [12:0] band;
    logic outBand;
    logic hit;
    logic [12:0] diff;
    logic [3:0] okNext;
    logic startTune;
    logic [1:0] nx;
    n = q;
    mutual = q.option_bank_zero[cssc_pkg::B0_MUTUAL];
    lpAct = (q.lpInt != 8'h00) && !q.zoom;
    atOn = !(q.proxSet[cssc_pkg::P_AT_OFF]
             && q.proxSet[cssc_pkg::P_AT_PART]);
    enMask = cssc_pkg::MASK_NP
             | {q.gest[cssc_pkg::G_THIRD_EN], 3'b000};
    if (lpAct) begin
      enMask = cssc_pkg::MASK_LP;
    end
    if (mutual) begin
      perCyc = q.option_bank_two[cssc_pkg::B2_DOUBLE]
        ? cssc_cyc(cssc_pkg::CT_MUT2_CYC)
        : cssc_cyc(cssc_pkg::CT_MUT_CYC);
    end else begin
      perCyc = q.option_bank_two[cssc_pkg::B2_DOUBLE]
        ? cssc_cyc(cssc_pkg::CT_SELF2_CYC)
        : cssc_cyc(cssc_pkg::CT_SELF_CYC);
    end
    c = q.xcnt;
    b = q.base[q.ch];
    thr = (q.ch == 2'd0) ? 13'(q.thrProx) : 13'(q.thrTouch);
    tgt = ((q.ch == 2'd0) ? 13'(q.tgtProx) : 13'(q.tgtTouch))
          << cssc_pkg::TGT_SCALE_SH;
    band = tgt >> cssc_pkg::BAND_SH;
    outBand = (13'(c) < tgt - band) || (13'(c) > tgt + band);
    if (mutual) begin
      hit = 13'(c) > 13'(b) + thr;
    end else begin
      hit = 13'(c) + thr < 13'(b);
    end
    diff = 13'(c) - 13'(b);
    okNext = q.tuneOk;
    startTune = 1'b0;
    nx = cssc_next(q.ch, enMask);
    n.drv.xfer = 1'b0;
    n.slotTmr = q.slotTmr + 20'd1;

    // --------------------------------------------------------
    unique case (q.st)
      cssc_pkg::ST_MEAS: begin
        // one shared capacitor: only the slot channel is charged
        n.drv.sel = 4'b0001 << q.ch;
        if (q.div >= perCyc - 8'd1) begin
          n.div = 8'h00;
          if (tripIn || q.xcnt == cssc_pkg::CNT_MAX) begin
            n.st = cssc_pkg::ST_CALC;
            n.drv.sel = 4'h0;
          end else begin
            n.drv.xfer = 1'b1;
            n.xcnt = q.xcnt + 12'd1;
          end
        end else begin
          n.div = q.div + 8'd1;
        end
      end
      cssc_pkg::ST_CALC: begin
        n.cnt[q.ch] = c;
        n.evt[q.ch] = hit && q.baseOk[q.ch] && !q.tuning;
        if (!q.baseOk[q.ch] || q.tuning) begin
          n.base[q.ch] = c;
          n.baseOk[q.ch] = 1'b1;
        end else if (diff[12] && diff[12:cssc_pkg::AVG_SH] == '1) begin
          n.base[q.ch] = (c == b) ? b : b - 12'd1;
        end else if (!diff[12] && diff[12:cssc_pkg::AVG_SH] == '0) begin
          n.base[q.ch] = (c == b) ? b : b + 12'd1;
        end else begin
          n.base[q.ch] = b + 12'(($signed(diff))
                         >>> cssc_pkg::AVG_SH);
        end
        if (q.ch == 2'd0) begin
          if (lpAct && hit && q.baseOk[0]) begin
            n.zoom = 1'b1;
          end else if (!hit) begin
            n.zoom = 1'b0;
          end
        end
        if (atOn) begin
          if (!q.tuning && (outBand || q.proxSet[cssc_pkg::P_RETUNE])) begin
            startTune = 1'b1;
          end
          if (q.tuning || startTune) begin
            if (outBand) begin
              // more compensation pulls the count down
              if (13'(c) > tgt) begin
                n.comp[q.ch] = (q.comp[q.ch] == 8'hff) ? 8'hff
                               : q.comp[q.ch] + 8'd1;
              end else begin
                n.comp[q.ch] = (q.comp[q.ch] == 8'h00) ? 8'h00
                               : q.comp[q.ch] - 8'd1;
              end
            end
            okNext = (startTune ? 4'h0 : q.tuneOk);
            okNext[q.ch] = !outBand;
            n.tuneOk = okNext;
            n.tuning = (okNext | ~enMask) != 4'hf;
          end
        end else begin
          n.tuning = 1'b0;
        end
        n.st = cssc_pkg::ST_WAIT;
      end
      cssc_pkg::ST_WAIT: begin
        if (q.slotTmr >= 20'(SAMPLE_CYC - 1)) begin
          n.slotTmr = 20'h0;
          n.div = 8'h00;
          n.xcnt = 12'h000;
          if (lpAct && nx == 2'd0) begin
            n.st = cssc_pkg::ST_SLEEP;
            n.lpTmr = cssc_lp(q.lpInt);
          end else begin
            n.ch = nx;
            n.st = cssc_pkg::ST_MEAS;
            n.drv.comp = q.comp[nx];
          end
        end
      end
      cssc_pkg::ST_SLEEP: begin
        n.slotTmr = 20'h0;
        if (q.lpTmr <= 32'd1 || !lpAct) begin
          n.ch = 2'd0;
          n.st = cssc_pkg::ST_MEAS;
          n.drv.comp = q.comp[0];
        end else begin
          n.lpTmr = q.lpTmr - 32'd1;
        end
      end
    endcase
    if (q.lpInt == 8'h00) begin
      n.zoom = 1'b0;
    end

    // idle channels follow the float option
    n.drv.ground = q.option_bank_zero[cssc_pkg::B0_FLOAT] ? 4'h0
                   : ~n.drv.sel;

    // --------------------------------------------------------
    // register writes; a host set lands after the clear
    if (startTune) begin
      n.proxSet[cssc_pkg::P_RETUNE] = 1'b0;
    end
    if (busReq.wr) begin
      unique case (busReq.addr)
        cssc_pkg::A_CHSEL: n.rdCh = busReq.wdata[1:0];
        cssc_pkg::A_OPTION_BANK_ZERO: n.option_bank_zero = busReq.wdata;
        cssc_pkg::A_OPTION_BANK_TWO: n.option_bank_two = busReq.wdata;
        cssc_pkg::A_GEST: n.gest = busReq.wdata;
        cssc_pkg::A_PROXSET: n.proxSet = busReq.wdata;
        cssc_pkg::A_LPINT: n.lpInt = busReq.wdata;
        cssc_pkg::A_TGT_PROX: n.tgtProx = busReq.wdata;
        cssc_pkg::A_TGT_TOUCH: n.tgtTouch = busReq.wdata;
        cssc_pkg::A_THR_PROX: n.thrProx = busReq.wdata;
        cssc_pkg::A_THR_TOUCH: n.thrTouch = busReq.wdata;
        default: ;
      endcase
    end

    // --------------------------------------------------------
    // read data, valid one cycle after the strobe only
    n.rdata = 8'h00;
    if (busReq.rd) begin
      unique case (busReq.addr)
        cssc_pkg::A_SYSFLAG: begin
          n.rdata[cssc_pkg::F_MUTUAL] = mutual;
          n.rdata[cssc_pkg::F_LP_ACT] = lpAct;
          n.rdata[cssc_pkg::F_AT_RUN] = q.tuning;
        end
        cssc_pkg::A_EVENT: n.rdata = {4'h0, q.evt};
        cssc_pkg::A_CHSEL: n.rdata = {6'h00, q.rdCh};
        cssc_pkg::A_CNT_H: n.rdata = {4'h0, q.cnt[q.rdCh][11:8]};
        cssc_pkg::A_CNT_L: n.rdata = q.cnt[q.rdCh][7:0];
        cssc_pkg::A_BASE_H: n.rdata = {4'h0, q.base[q.rdCh][11:8]};
        cssc_pkg::A_BASE_L: n.rdata = q.base[q.rdCh][7:0];
        cssc_pkg::A_COMP: n.rdata = q.comp[q.rdCh];
        cssc_pkg::A_OPTION_BANK_ZERO: n.rdata = q.option_bank_zero;
        cssc_pkg::A_OPTION_BANK_TWO: n.rdata = q.option_bank_two;
        cssc_pkg::A_GEST: n.rdata = q.gest;
        cssc_pkg::A_PROXSET: n.rdata = q.proxSet;
        cssc_pkg::A_LPINT: n.rdata = q.lpInt;
        cssc_pkg::A_TGT_PROX: n.rdata = q.tgtProx;
        cssc_pkg::A_TGT_TOUCH: n.rdata = q.tgtTouch;
        cssc_pkg::A_THR_PROX: n.rdata = q.thrProx;
        cssc_pkg::A_THR_TOUCH: n.rdata = q.thrTouch;
        default: n.rdata = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
      q.st <= cssc_pkg::ST_MEAS;
      q.comp <= {4{cssc_pkg::RST_COMP}};
      q.drv.comp <= cssc_pkg::RST_COMP;
      q.tuning <= 1'b1;
      q.tgtProx <= cssc_pkg::RST_TGT_PROX;
      q.tgtTouch <= cssc_pkg::RST_TGT_TOUCH;
      q.thrProx <= cssc_pkg::RST_THR_PROX;
      q.thrTouch <= cssc_pkg::RST_THR_TOUCH;
    end else begin
      q <= n;
    end
  end

endmodule

// file: cssc_scan_props.sv
`timescale 1ns/1ps
module cssc_scan_props #(
  parameter int SAMPLE_CYC = 1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // watched ports
  input wire cssc_pkg::cssc_bus_t busReq,
  input wire logic [7:0] regRdata,
  input wire logic tripIn,
  input wire cssc_pkg::cssc_drive_t drive,
  input wire logic [3:0] eventOut
);
  // ======
  // slot, transfer and read port rules
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_one_slot: assert property ($onehot0(drive.sel))
    else $error("two channels charged at once");
  a_slot_holds: assert property (drive.sel != 4'h0 |=>
    drive.sel == $past(drive.sel) || drive.sel == 4'h0)
    else $error("slot channel changed mid measurement");
  a_idle_ground: assert property ((drive.ground & drive.sel) == 4'h0)
    else $error("charged channel also grounded");
  a_xfer_in_slot: assert property (drive.xfer |-> drive.sel != 4'h0)
    else $error("transfer pulse outside a slot");
  a_trip_ends: assert property (tripIn |-> ##[0:260] drive.sel == 4'h0)
    else $error("measurement ran on after trip");
  a_xfer_gap: assert property (drive.xfer |=> !drive.xfer [*8])
    else $error("transfer pulses too close");
  a_comp_holds: assert property (
    drive.sel != 4'h0 && $stable(drive.sel) |-> $stable(drive.comp))
    else $error("compensation moved inside a slot");
  a_event_calc: assert property (!$stable(eventOut) |-> drive.sel == 4'h0)
    else $error("event state changed during charging");
  a_rdata_idle: assert property (!$past(busReq.rd) |-> regRdata == 8'h0)
    else $error("read data outside answer cycle");
  c_event: cover property ($rose(|eventOut));
  c_third: cover property ($rose(drive.sel[3]));
  c_trip: cover property (tripIn ##1 drive.sel == 4'h0);
endmodule

bind cssc_scan cssc_scan_props #(.SAMPLE_CYC(SAMPLE_CYC)) i_cssc_scan_props (
  .clk_sys(clk_sys), .resetn(resetn), .busReq(busReq), .regRdata(regRdata),
  .tripIn(tripIn), .drive(drive), .eventOut(eventOut));

// file: cssc_electrode.sv
`timescale 1ns/1ps
module cssc_electrode (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // electrode side
  input wire cssc_pkg::cssc_drive_t drive,
  input wire logic [3:0][11:0] tripAt,
  output logic tripIn
);
  // ======
  // charge counting
  logic [11:0] pulseCnt_ff;
  logic [1:0] ch;
  always_comb begin
    ch = 2'h0;
    for (int i = 0; i < 4; i++)
      if (drive.sel[i]) ch = i[1:0];
  end
  // capacitor drains between slots, so the count restarts per slot
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) pulseCnt_ff <= 12'h0;
    else if (drive.sel == 4'h0) pulseCnt_ff <= 12'h0;
    else if (drive.xfer) pulseCnt_ff <= pulseCnt_ff + 12'h1;
  end
  assign tripIn = drive.sel != 4'h0 && pulseCnt_ff >= tripAt[ch];
endmodule

// file: cssc_scan_test.sv
`timescale 1ns/1ps
module cssc_scan_test;
  // ======
  // setup
  localparam int SMP = 1200;
  localparam int LPU = 400;
  localparam logic [7:0] FLG = cssc_pkg::A_SYSFLAG;
  localparam logic [7:0] PRX = cssc_pkg::A_PROXSET;
  localparam logic [7:0] RA [7] = '{FLG, cssc_pkg::A_TGT_PROX,
    cssc_pkg::A_TGT_TOUCH, cssc_pkg::A_THR_PROX, cssc_pkg::A_THR_TOUCH,
    cssc_pkg::A_COMP, 8'h05};
  localparam logic [7:0] RE [7] = '{8'h04, cssc_pkg::RST_TGT_PROX,
    cssc_pkg::RST_TGT_TOUCH, cssc_pkg::RST_THR_PROX,
    cssc_pkg::RST_THR_TOUCH, cssc_pkg::RST_COMP, 8'h00};
  localparam int PER [4] = '{cssc_pkg::CT_SELF_CYC, cssc_pkg::CT_SELF2_CYC,
    cssc_pkg::CT_MUT_CYC, cssc_pkg::CT_MUT2_CYC};
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  cssc_pkg::cssc_bus_t busReq = '0;
  logic [7:0] regRdata;
  logic tripIn;
  cssc_pkg::cssc_drive_t drive;
  logic [3:0] eventOut;
  logic [3:0][11:0] tripAt = {4{12'h008}};
  logic [3:0] prevSel = 4'h0;
  logic [3:0] seq[$];
  int starts[$];
  int cyc = 0;
  int n_mismatch = 0;
  int samples_checked = 0;

  cssc_scan #(.SAMPLE_CYC(SMP), .LP_UNIT_CYC(LPU), .LP_ONE_CYC(300),
    .LP_TWO_CYC(600)) i_cssc_scan (.clk_sys(clk_sys), .resetn(resetn),
    .busReq(busReq), .regRdata(regRdata), .tripIn(tripIn), .drive(drive),
    .eventOut(eventOut));
  cssc_electrode i_cssc_electrode (.clk_sys(clk_sys), .resetn(resetn),
    .drive(drive), .tripAt(tripAt), .tripIn(tripIn));

  initial forever #4 clk_sys = ~clk_sys;
  // slot starts, stamped in clock cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    prevSel <= drive.sel;
    if (drive.sel != 4'h0 && drive.sel != prevSel) begin
      seq.push_back(drive.sel);
      starts.push_back(cyc);
    end
  end

  // ======
  // helpers
  function automatic logic [3:0] after(input logic [3:0] s,
                                       input logic [3:0] en);
    logic [3:0] n;
    n = s;
    for (int k = 0; k < 4; k++) begin
      n = {n[2:0], n[3]};
      if ((n & en) != 4'h0) return n;
    end
    return n;
  endfunction
  task automatic check(input string w, input logic [31:0] e,
                       input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    busReq.wr <= 1'b0;
  endtask
  task automatic rc(input string w, input logic [7:0] a,
                    input logic [7:0] m, input logic [7:0] e);
    logic [7:0] v;
    @(posedge clk_sys);
    busReq <= '{addr: a, wdata: 8'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    busReq.rd <= 1'b0;
    #1 v = regRdata;
    check(w, {24'h0, e}, {24'h0, v & m});
  endtask
  task automatic slots(input int n);
    seq.delete();
    starts.delete();
    repeat (n * (SMP + 4 * LPU)) begin
      if (seq.size() >= n) break;
      @(posedge clk_sys);
    end
  endtask
  task automatic ord(input int n, input logic [3:0] en);
    slots(n);
    for (int i = 1; i < n; i++)
      check("slot order", {28'h0, after(seq[i-1], en)}, {28'h0, seq[i]});
  endtask
  task automatic waitCh(input logic [3:0] c);
    repeat (6) begin
      slots(1);
      if (seq[0] == c) break;
    end
  endtask
  // one sample of channels 0 and 1 at count v, then the event bits
  task automatic evt(input logic [11:0] v, input logic [1:0] e);
    slots(3);
    rc("tuning idle", FLG, 8'h04, 8'h00);
    waitCh(4'h4);
    tripAt[1:0] <= {v, v};
    waitCh(4'h4);
    check("events", {30'h0, e}, {30'h0, eventOut[1:0]});
    tripAt <= {4{12'h008}};
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ======
  // tests
  initial begin
    int t0;
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int i = 0; i < 7; i++)
      rc("reset", RA[i], 8'hff, RE[i]);
    // small targets keep each count at eight transfers
    wr(cssc_pkg::A_TGT_PROX, 8'h01);
    wr(cssc_pkg::A_TGT_TOUCH, 8'h01);
    wr(cssc_pkg::A_THR_PROX, 8'h00);
    wr(cssc_pkg::A_THR_TOUCH, 8'h01);
    wr(cssc_pkg::A_OPTION_BANK_TWO, 8'h01);
    $display("test reset done");
    ord(4, 4'h7);
    check("slot time", SMP, 32'(starts[1] - starts[0]));
    check("round", 3 * SMP, 32'(starts[3] - starts[0]));
    #1 check("ground", {28'h0, ~drive.sel}, {28'h0, drive.ground});
    wr(cssc_pkg::A_GEST, 8'h01);
    ord(5, 4'hf);
    wr(cssc_pkg::A_GEST, 8'h00);
    wr(cssc_pkg::A_CHSEL, 8'h01);
    rc("count high", cssc_pkg::A_CNT_H, 8'hff, 8'h00);
    rc("count low", cssc_pkg::A_CNT_L, 8'hff, 8'h08);
    rc("base low", cssc_pkg::A_BASE_L, 8'hff, 8'h08);
    wr(cssc_pkg::A_OPTION_BANK_ZERO, 8'h01);
    slots(1);
    #1 check("float", 32'h0, {28'h0, drive.ground});
    $display("test slots done");
    for (int m = 0; m < 4; m++) begin
      wr(cssc_pkg::A_OPTION_BANK_ZERO, m[1] ? 8'h08 : 8'h00);
      wr(cssc_pkg::A_OPTION_BANK_TWO, m[0] ? 8'h01 : 8'h00);
      slots(1);
      // sample at the clock edge, so both stamps see the same cycle count
      do @(posedge clk_sys); while (!drive.xfer);
      t0 = cyc;
      do @(posedge clk_sys); while (!drive.xfer);
      check("xfer period", PER[m], 32'(cyc - t0));
      rc("mutual flag", FLG, 8'h01, m[1] ? 8'h01 : 8'h00);
    end
    $display("test rates done");
    evt(12'h009, 2'b01);
    wr(cssc_pkg::A_OPTION_BANK_ZERO, 8'h00);
    evt(12'h007, 2'b01);
    evt(12'h009, 2'b00);
    $display("test events done");
    tripAt[1] <= 12'h00c;
    slots(4);
    rc("band retune", FLG, 8'h04, 8'h04);
    tripAt[1] <= 12'h008;
    slots(4);
    rc("tuned", FLG, 8'h04, 8'h00);
    // request only while idle: a running tuning keeps the bit pending
    wr(PRX, 8'h04);
    slots(4);
    rc("retune clear", PRX, 8'h04, 8'h00);
    wr(PRX, 8'h03);
    tripAt[1] <= 12'h00c;
    slots(3);
    rc("tuning off", FLG, 8'h04, 8'h00);
    tripAt[1] <= 12'h008;
    $display("test tuning done");
    wr(cssc_pkg::A_LPINT, 8'h03);
    waitCh(4'h1);
    rc("low power", FLG, 8'h02, 8'h02);
    ord(3, 4'h1);
    check("lp gap", SMP + 3 * LPU, 32'(starts[2] - starts[1]));
    tripAt[0] <= 12'h007;
    waitCh(4'h2);
    check("zoom", 32'h2, {28'h0, seq[0]});
    rc("zoomed", FLG, 8'h02, 8'h00);
    tripAt[0] <= 12'h008;
    $display("test low power done");
    final_report();
  end

  initial begin
    repeat (98000) @(posedge clk_sys);
    n_mismatch++;
    $display("BAD watchdog expected finish seen hang");
    final_report();
  end
endmodule
